// ### spc_core.sv
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module spc_core
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] sck_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic [1:0] miso_sync_reg;
  logic [1:0] ss_sync_reg;
  logic       sck_prev_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_sync_reg  <= 2'h0;
      mosi_sync_reg <= 2'h0;
      miso_sync_reg <= 2'h0;
      ss_sync_reg   <= 2'h3;
      sck_prev_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      sck_sync_reg  <= {sck_sync_reg[0], sck_i};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
      miso_sync_reg <= {miso_sync_reg[0], miso_i};
      ss_sync_reg   <= {ss_sync_reg[0], ss_n_i};
      sck_prev_reg  <= sck_sync_reg[1];
    end
  end

  wire sck_s  = sck_sync_reg[1];
  wire ss_n_s = ss_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;

  wire irq_en    = ctrl_reg[spc_pkg::BIT_IRQ_EN];
  wire port_en   = ctrl_reg[spc_pkg::BIT_PORT_EN];
  wire div2_by   = ctrl_reg[spc_pkg::BIT_DIV2_BY];
  wire ctrl_mode = ctrl_reg[spc_pkg::BIT_CTRL];
  wire idle_lvl  = ctrl_reg[spc_pkg::BIT_IDLE];
  wire phase     = ctrl_reg[spc_pkg::BIT_PHASE];
  wire [2:0] rate_code = {div2_by, ctrl_reg[spc_pkg::BIT_RATE1],
                          ctrl_reg[spc_pkg::BIT_RATE0]};

  // mode fault: controller enabled and select pulled low
  wire mode_fault = port_en && ctrl_mode && !ss_n_s;

  ////////////////////////////////////////////////////////////////////////
  // axi-lite write path: take address and data in either order
  logic       aw_hold_reg;
  logic [3:0] aw_addr_reg;
  logic       w_hold_reg;
  logic [7:0] w_data_reg;
  logic       w_strb_reg;

  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  wire wr_fire   = aw_hold_reg && w_hold_reg;
  wire wr_ctrl   = wr_fire && aw_addr_reg == spc_pkg::ADDR_CONTROL
                   && w_strb_reg;
  wire wr_mask   = wr_fire && aw_addr_reg == spc_pkg::ADDR_MASK
                   && w_strb_reg;
  wire wr_mapped = aw_addr_reg == spc_pkg::ADDR_CONTROL
                   || aw_addr_reg == spc_pkg::ADDR_STATUS
                   || aw_addr_reg == spc_pkg::ADDR_MASK;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg  <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_hold_reg   <= 1'b0;
      w_data_reg   <= 8'h00;
      w_strb_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= spc_pkg::AXI_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? spc_pkg::AXI_OKAY : spc_pkg::AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi-lite read path
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'b00};
  wire rd_status = rd_take && rd_addr == spc_pkg::ADDR_STATUS;
  assign s_axi_arready = !s_axi_rvalid;

  wire [31:0] rd_word =
    rd_addr == spc_pkg::ADDR_CONTROL ? {24'h000000, ctrl_reg} :
    rd_addr == spc_pkg::ADDR_STATUS  ? {29'h00000000, status_reg} :
    rd_addr == spc_pkg::ADDR_MASK    ? {29'h00000000, mask_reg} :
    32'h00000000;
  wire rd_mapped = rd_addr == spc_pkg::ADDR_CONTROL
                   || rd_addr == spc_pkg::ADDR_STATUS
                   || rd_addr == spc_pkg::ADDR_MASK;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= spc_pkg::AXI_OKAY;
    end
    else if (clk_en)
    begin
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_mapped ? spc_pkg::AXI_OKAY : spc_pkg::AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control, status and mask registers
  logic ev_done;
  logic ev_ovr;
  wire [2:0] ev_set = {ev_ovr, mode_fault, ev_done};

  // hardware clear of port enable and controller select wins over a write
  wire [7:0] ctrl_wr = wr_ctrl ? w_data_reg : ctrl_reg;
  wire [7:0] ctrl_next = mode_fault
    ? (ctrl_wr & ~(8'h01 << spc_pkg::BIT_PORT_EN)
               & ~(8'h01 << spc_pkg::BIT_CTRL))
    : ctrl_wr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // lower bits undefined by design; zero chosen
      ctrl_reg   <= {spc_pkg::CTRL_UPPER_RESET,
                     spc_pkg::CTRL_LOWER_RESET};
      status_reg <= 3'h0;
      mask_reg   <= spc_pkg::MASK_RESET;
    end
    else if (clk_en)
    begin
      ctrl_reg   <= ctrl_next;
      // set wins over the clear-on-read
      status_reg <= (rd_status ? 3'h0 : status_reg) | ev_set;
      if (wr_mask)
        mask_reg <= w_data_reg[2:0];
    end
  end

  assign irq = irq_en && |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////
  // controller clock divider
  logic [6:0] half_cnt;
  always_comb
  begin
    case (rate_code)
      spc_pkg::RATE_DIV4:   half_cnt = spc_pkg::HALF_DIV4;
      spc_pkg::RATE_DIV8:   half_cnt = spc_pkg::HALF_DIV8;
      spc_pkg::RATE_DIV16:  half_cnt = spc_pkg::HALF_DIV16;
      spc_pkg::RATE_DIV32:  half_cnt = spc_pkg::HALF_DIV32;
      spc_pkg::RATE_DIV64:  half_cnt = spc_pkg::HALF_DIV64;
      spc_pkg::RATE_DIV128: half_cnt = spc_pkg::HALF_DIV128;
      default:              half_cnt = spc_pkg::HALF_DIV128;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // shift engine
  spc_pkg::spc_state_t state_reg;
  logic [6:0] div_reg;
  logic [3:0] edge_reg;
  logic [7:0] shift_reg;
  logic       sck_lvl_reg;
  logic       rx_valid_reg;
  logic [7:0] rx_data_reg;
  logic       cap_dly_reg;  // miso lags sck by the synchroniser

  // target edges come from outside; rate bits are not consulted there
  wire tgt_edge = !ctrl_mode && !ss_n_s && sck_s != sck_prev_reg;
  wire ctl_edge = ctrl_mode && state_reg == spc_pkg::SPC_RUN
                  && div_reg == 7'h01;
  wire any_edge = port_en && (ctrl_mode ? ctl_edge : tgt_edge);
  // odd edges capture with phase clear, even edges with phase set
  wire capture  = any_edge && (edge_reg[0] == phase);
  wire data_in  = ctrl_mode ? miso_sync_reg[1] : mosi_sync_reg[1];
  wire cap_take = ctrl_mode ? cap_dly_reg : capture;
  wire [7:0] shift_in = {shift_reg[6:0], data_in};
  localparam int EDGES = 2 * int'(spc_pkg::BITS_PER_BYTE);
  wire last_edge = edge_reg == 4'(EDGES - 1);
  wire start_ok = port_en && ctrl_mode && tx_valid
                  && state_reg == spc_pkg::SPC_IDLE;
  wire tgt_load = port_en && !ctrl_mode && tx_valid
                  && state_reg == spc_pkg::SPC_IDLE;

  assign tx_ready = start_ok || tgt_load;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= spc_pkg::SPC_IDLE;
      div_reg      <= 7'h00;
      edge_reg     <= 4'h0;
      shift_reg    <= 8'h00;
      sck_lvl_reg  <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_data_reg  <= 8'h00;
      cap_dly_reg  <= 1'b0;
      ev_done      <= 1'b0;
      ev_ovr       <= 1'b0;
    end
    else if (clk_en)
    begin
      ev_done      <= 1'b0;
      ev_ovr       <= 1'b0;
      rx_valid_reg <= 1'b0;
      cap_dly_reg  <= ctrl_mode && capture;
      if (!port_en || mode_fault)
      begin
        state_reg   <= spc_pkg::SPC_IDLE;
        edge_reg    <= 4'h0;
        sck_lvl_reg <= idle_lvl;
      end
      else
      begin
        if (cap_take)
          shift_reg <= shift_in;
        case (state_reg)
          spc_pkg::SPC_IDLE:
          begin
            sck_lvl_reg <= idle_lvl;
            edge_reg    <= 4'h0;
            div_reg     <= half_cnt;
            if (tx_ready)
            begin
              shift_reg <= tx_data;
              state_reg <= spc_pkg::SPC_RUN;
            end
            else if (tgt_edge)
              ev_ovr <= 1'b1;  // byte clocked with nothing loaded
          end
          spc_pkg::SPC_RUN:
          begin
            if (ctrl_mode)
              div_reg <= (div_reg == 7'h01) ? half_cnt : div_reg - 7'h01;
            if (ctl_edge)
              sck_lvl_reg <= ~sck_lvl_reg;
            if (any_edge)
              edge_reg <= edge_reg + 4'h1;
            if (any_edge && last_edge)
              state_reg <= spc_pkg::SPC_DONE;
          end
          spc_pkg::SPC_DONE:
          begin
            // unread byte still pending means overrun
            ev_ovr       <= rx_valid_reg;
            ev_done      <= 1'b1;
            rx_valid_reg <= 1'b1;
            rx_data_reg  <= cap_dly_reg ? shift_in : shift_reg;
            sck_lvl_reg  <= idle_lvl;
            state_reg    <= spc_pkg::SPC_IDLE;
          end
          default: state_reg <= spc_pkg::SPC_IDLE;
        endcase
      end
    end
  end

  assign rx_valid = rx_valid_reg;
  assign rx_data  = rx_data_reg;

  ////////////////////////////////////////////////////////////////////////
  // pin drive: nothing leaves the block while the port is disabled
  wire tx_bit = shift_reg[7];
  assign sck_o   = sck_lvl_reg;
  assign sck_oe  = port_en && ctrl_mode;
  assign mosi_o  = tx_bit;
  assign mosi_oe = port_en && ctrl_mode;
  assign miso_o  = tx_bit;
  assign miso_oe = port_en && !ctrl_mode && !ss_n_s;

endmodule

`default_nettype wire

// ### spc_pkg.sv
package spc_pkg;

  // register byte addresses on the AXI4-Lite slave
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_MASK    = 4'h8;

  // control register field positions
  localparam int BIT_IRQ_EN  = 7;
  localparam int BIT_PORT_EN = 6;
  localparam int BIT_DIV2_BY = 5;
  localparam int BIT_CTRL    = 4;
  localparam int BIT_IDLE    = 3;
  localparam int BIT_PHASE   = 2;
  localparam int BIT_RATE1   = 1;
  localparam int BIT_RATE0   = 0;

  // status / mask field positions
  localparam int BIT_DONE    = 0;
  localparam int BIT_FAULT   = 1;
  localparam int BIT_OVR     = 2;

  localparam logic [3:0] CTRL_UPPER_RESET = 4'h0;
  localparam logic [3:0] CTRL_LOWER_RESET = 4'h0;
  localparam logic [2:0] MASK_RESET       = 3'h7;

  // half-period of serial clock in cpu cycles, per rate code
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  localparam logic [2:0] RATE_DIV4   = 3'h4;
  localparam logic [2:0] RATE_DIV8   = 3'h0;
  localparam logic [2:0] RATE_DIV16  = 3'h1;
  localparam logic [2:0] RATE_DIV32  = 3'h6;
  localparam logic [2:0] RATE_DIV64  = 3'h2;
  localparam logic [2:0] RATE_DIV128 = 3'h3;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [1:0] {
    SPC_IDLE = 2'b00,
    SPC_RUN  = 2'b01,
    SPC_DONE = 2'b10
  } spc_state_t;

endpackage

// ### spc_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spc_core_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ss_n_i,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic irq,
  input wire logic rx_valid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_quiet;
    $rose(aresetn) |-> !sck_oe && !mosi_oe && !miso_oe && !irq;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("pins or irq active after reset");
  property p_roles;
    sck_oe |-> mosi_oe && !miso_oe;
  endproperty
  a_roles: assert property (p_roles)
    else $error("data pin roles wrong for controller");
  property p_fault;
    sck_oe && !ss_n_i |-> ##[1:5] !sck_oe;
  endproperty
  a_fault: assert property (p_fault)
    else $error("select low did not drop controller");
  property p_sck_min;
    sck_oe && $changed(sck_o) |=> $stable(sck_o);
  endproperty
  a_sck_min: assert property (p_sck_min)
    else $error("serial clock faster than cpu/4");
  property p_sck_end;
    rx_valid |-> $stable(sck_o);
  endproperty
  a_sck_end: assert property (p_sck_end)
    else $error("serial clock moved at end of byte");
  property p_rx_pulse;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("rx_valid longer than one cycle");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("bvalid dropped before bready");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("rvalid dropped before rready");
endmodule
bind spc_core spc_core_chk spc_core_chk_inst (
  .aclk        (aclk),
  .aresetn     (aresetn),
  .ss_n_i      (ss_n_i),
  .sck_o       (sck_o),
  .sck_oe      (sck_oe),
  .mosi_oe     (mosi_oe),
  .miso_oe     (miso_oe),
  .irq         (irq),
  .rx_valid    (rx_valid),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ### spc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module spc_peer
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_idle_level,
  input  wire logic       capture_phase,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      got
);
  int idx;
  initial
  begin
    miso = 1'b0;
    got = 8'h00;
  end
  always @(negedge sel_n)
  begin
    idx = capture_phase ? 8 : 7;
    miso = tx[7];
  end
  // released line must not keep a stale bit
  always @(posedge sel_n) miso = ~miso;
  always @(sck)
    if (!sel_n)
    begin
      if ((sck != clock_idle_level) ^ capture_phase)
        got = {got[6:0], mosi};
      else if (idx > 0)
      begin
        idx = idx - 1;
        miso = tx[idx];
      end
    end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [3:0] CT = spc_pkg::ADDR_CONTROL;
  localparam logic [3:0] ST = spc_pkg::ADDR_STATUS;
  localparam logic [3:0] MK = spc_pkg::ADDR_MASK;
  localparam logic [7:0] TGT_PAT = 8'h96;
  // rate codes ordered /4 ... /128
  localparam logic [2:0] RC [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        tx_valid, tx_ready, rx_valid, sck_i, sck_o, sck_oe;
  logic        mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
  logic        ss_n_i, irq, sel_n, pol, pha, peer_miso, ext_sck, ext_mosi;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [7:0]  tx_data, rx_data, peer_got, tgt_got;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          err_count, compares, n;
  assign sck_i  = sck_oe ? sck_o : ext_sck;
  assign mosi_i = mosi_oe ? mosi_o : ext_mosi;
  assign miso_i = miso_oe ? miso_o : peer_miso;
  spc_core spc_core_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o),
    .miso_oe(miso_oe), .ss_n_i(ss_n_i), .irq(irq));
  spc_peer spc_peer_inst (.sck(sck_i), .mosi(mosi_i), .sel_n(sel_n),
    .clock_idle_level(pol), .capture_phase(pha), .tx(8'h5A), .miso(peer_miso), .got(peer_got));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", 3'h4, {s_axi_bvalid, s_axi_bresp});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input string nm, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    chk("rresp", {1'b1, r}, {s_axi_rvalid, s_axi_rresp});
    chk(nm, e, s_axi_rdata);
  endtask
  task automatic xfer(input int i);
    logic [7:0] c;
    int hi;
    c = {2'b10, RC[i][2], 1'b1, i[0], i[1], RC[i][1:0]};
    pol = i[0];
    pha = i[1];
    wr(CT, c);
    wr(CT, c | 8'h40);
    chk("sck_idle", pol, sck_o);
    sel_n <= 1'b0;
    tx_valid <= 1'b1;
    hi = 0;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (tx_ready) tx_valid <= 1'b0;
      if (sck_o !== pol) hi++;
    end
    while (!rx_valid && n < 3000);
    sel_n <= 1'b1;
    chk("rx_data", 8'h5A, rx_data);
    chk("peer_got", 8'h3C, peer_got);
    chk("sck_busy", 16 << i, hi);
    @(posedge aclk);
    chk("irq_done", 1, irq);
    rd(ST, 1, "stat_done");
    chk("irq_clr", 0, irq);
    rd(CT, c | 8'h40, "ctrl_rb");
  endtask
  initial
  begin
    err_count = 0;
    compares = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, tx_valid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'h1;
    tx_data = 8'h3C;
    clk_en = 1'b1;
    ss_n_i = 1'b1;
    {ext_sck, ext_mosi} = 2'h0;
    tgt_got = 8'h00;
    sel_n = 1'b1;
    {pol, pha} = 2'h0;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CT, 0, "ctrl_rst");
    rd(MK, 7, "mask_rst");
    rd(ST, 0, "stat_rst");
    rd(4'hC, 0, "unmapped", 2'h2);
    wr(CT, 8'hBF);
    rd(CT, 32'hBF, "ctrl_rw");
    for (int i = 0; i < 6; i++) xfer(i);
    wr(CT, 8'hD0);
    ss_n_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (sck_oe && n < 10);
    ss_n_i <= 1'b1;
    rd(CT, 32'h80, "ctrl_fault");
    chk("sck_oe", 0, sck_oe);
    chk("irq_fault", 1, irq);
    wr(MK, 8'h00);
    chk("irq_masked", 0, irq);
    wr(MK, 8'h07);
    chk("irq_unmask", 1, irq);
    rd(ST, 2, "stat_fault");
    chk("irq_off", 0, irq);
    // target role, rate bits set but the clock comes from the bench
    wr(CT, 8'hC3);
    tx_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!tx_ready && n < 10);
    tx_valid <= 1'b0;
    ss_n_i <= 1'b0;
    for (int b = 7; b >= 0; b--)
    begin
      ext_mosi <= TGT_PAT[b];
      repeat (8) @(posedge aclk);
      ext_sck <= 1'b1;
      tgt_got = {tgt_got[6:0], miso_i};
      repeat (8) @(posedge aclk);
      ext_sck <= 1'b0;
    end
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!rx_valid && n < 20);
    chk("tgt_rx", TGT_PAT, rx_data);
    chk("tgt_miso", 8'h3C, tgt_got);
    ss_n_i <= 1'b1;
    rd(ST, 1, "stat_tgt");
    end_of_test;
  end
  initial
  begin
    #2000000;
    err_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
